/* rtl/iawdc_defs.vh */
// constants for the acknowledge wait / daisy chain glue block
// assumes inclusion by bare name from rtl/ design files
`ifndef IAWDC_DEFS_VH
`define IAWDC_DEFS_VH

// ==========================================================
// wait-state counter
`define IAWDC_CNT_W       4
`define IAWDC_CNT_BASE    4'hf
`define IAWDC_CNT_ONE     4'h1
`define IAWDC_CNT_ZERO    4'h0
`define IAWDC_ADD_WAIT    4'h2

// ==========================================================
// daisy chain and opcode bytes
`define IAWDC_CHAIN_N     8
`define IAWDC_OPC_PREFIX  8'hed
`define IAWDC_OPC_RETURN  8'h4d

// ==========================================================
// sequencer states
`define IAWDC_ST_IDLE     2'h0
`define IAWDC_ST_WAIT     2'h1
`define IAWDC_ST_VECTOR   2'h2
`define IAWDC_ST_DONE     2'h3

`endif

/* rtl/iawdc_glue.v */
// acknowledge wait-state and daisy chain glue logic
// assumes cpu strobes are active-low pins, sampled on clk_sys_in
`timescale 1ns/10ps
`default_nettype none
`include "iawdc_defs.vh"

module iawdc_glue (
    input  wire                          clk_sys_in,
    input  wire                          rst_n_in,
    input  wire                          opcode_fetch_cycle_n_in,
    input  wire                          rd_n_in,
    input  wire                          wr_n_in,
    input  wire                          io_request_strobe_n_in,
    input  wire [7:0]                    data_bus_in,
    input  wire [`IAWDC_CNT_W-1:0]       add_wait_in,
    input  wire                          snoop_enable_in,
    input  wire [`IAWDC_CHAIN_N-1:0]     chain_enable_out_in,
    output reg                           wait_n_out,
    output reg                           delayed_io_request_n_out,
    output reg                           vector_acknowledge_n_out,
    output reg                           periph_rd_n_out,
    output reg                           periph_wr_n_out,
    output reg  [`IAWDC_CHAIN_N-1:0]     chain_enable_in_out,
    output reg                           return_prefix_seen_out,
    output reg                           chain_settled_out
);
    // ==========================================================
    // pin synchronisers
    wire m1_n_s;
    wire rd_n_s;
    wire wr_n_s;
    wire delayed_io_request_n_s;

    iawdc_sync3 u_sync_m1 (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (opcode_fetch_cycle_n_in),
        .rst_val_in (1'b1),
        .level_out  (m1_n_s)
    );
    iawdc_sync3 u_sync_rd (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (rd_n_in),
        .rst_val_in (1'b1),
        .level_out  (rd_n_s)
    );
    iawdc_sync3 u_sync_wr (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (wr_n_in),
        .rst_val_in (1'b1),
        .level_out  (wr_n_s)
    );
    iawdc_sync3 u_sync_delayed_io_request (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (io_request_strobe_n_in),
        .rst_val_in (1'b1),
        .level_out  (delayed_io_request_n_s)
    );

    // ==========================================================
    // acknowledge detect: fetch active, read inactive
    wire ack_cycle;
    wire cpu_delayed_io_request;

    assign ack_cycle = !m1_n_s && rd_n_s;
    assign cpu_delayed_io_request  = !delayed_io_request_n_s;

    // ==========================================================
    // wait-state sequencer
    reg [1:0]                state_reg;
    reg [1:0]                state_next;
    reg [`IAWDC_CNT_W-1:0]   cnt_reg;
    reg [`IAWDC_CNT_W-1:0]   cnt_next;
    wire [`IAWDC_CNT_W-1:0]  preset;

    // preset is base minus added waits; counts up to base
    assign preset = `IAWDC_CNT_BASE - add_wait_in;

    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            `IAWDC_ST_IDLE: begin
                if (ack_cycle) begin
                    cnt_next   = preset;
                    state_next = `IAWDC_ST_WAIT;
                end
            end
            `IAWDC_ST_WAIT: begin
                // extra waits counted only once cpu's own waits reach delayed_io_request
                if (!ack_cycle) begin
                    state_next = `IAWDC_ST_IDLE;
                end else if (cpu_delayed_io_request) begin
                    if (cnt_reg == `IAWDC_CNT_BASE) begin
                        state_next = `IAWDC_ST_VECTOR;
                    end else begin
                        cnt_next = cnt_reg + `IAWDC_CNT_ONE;
                    end
                end
            end
            `IAWDC_ST_VECTOR: begin
                if (!cpu_delayed_io_request || !ack_cycle) begin
                    state_next = `IAWDC_ST_DONE;
                end
            end
            `IAWDC_ST_DONE: begin
                if (m1_n_s) begin
                    state_next = `IAWDC_ST_IDLE;
                end
            end
            default: begin
                state_next = `IAWDC_ST_IDLE;
                cnt_next   = `IAWDC_CNT_ZERO;
            end
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_reg <= `IAWDC_ST_IDLE;
            cnt_reg   <= `IAWDC_CNT_ZERO;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ==========================================================
    // strobes to cpu and peripherals
    wire in_vector;
    wire hold_wait;

    assign in_vector = (state_next == `IAWDC_ST_VECTOR);
    // only from the wait state, so the low span is exactly add_wait_in cycles
    assign hold_wait = (state_reg == `IAWDC_ST_WAIT) && (state_next == `IAWDC_ST_WAIT) && cpu_delayed_io_request;

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wait_n_out               <= 1'b1;
            delayed_io_request_n_out <= 1'b1;
            vector_acknowledge_n_out <= 1'b1;
            periph_rd_n_out          <= 1'b1;
            periph_wr_n_out          <= 1'b1;
        end else begin
            wait_n_out               <= !hold_wait;
            delayed_io_request_n_out <= !(in_vector && snoop_enable_in);
            vector_acknowledge_n_out <= !(ack_cycle && state_next != `IAWDC_ST_IDLE);
            // read strobe forced during vector phase of acknowledge
            periph_rd_n_out          <= !(in_vector || (!rd_n_s && m1_n_s));
            periph_wr_n_out          <= wr_n_s;
        end
    end

    // ==========================================================
    // return opcode snoop: prefix byte raises return_prefix_seen_out for the chain
    reg prefix_reg;
    reg fetch_d_reg;
    wire fetch_rd;

    assign fetch_rd = !m1_n_s && !rd_n_s;

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            prefix_reg  <= 1'b0;
            fetch_d_reg <= 1'b0;
        end else begin
            fetch_d_reg <= fetch_rd;
            if (fetch_rd && !fetch_d_reg) begin
                prefix_reg <= (data_bus_in == `IAWDC_OPC_PREFIX);
            end
        end
    end

    // ==========================================================
    // look-ahead chain enables
    reg [`IAWDC_CHAIN_N-1:0] la_next;
    integer i;

    always @* begin
        la_next    = {`IAWDC_CHAIN_N{1'b0}};
        la_next[0] = 1'b1;
        for (i = 1; i < `IAWDC_CHAIN_N; i = i + 1) begin
            la_next[i] = la_next[i-1] && chain_enable_out_in[i-1];
        end
    end

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            chain_enable_in_out    <= {`IAWDC_CHAIN_N{1'b1}};
            return_prefix_seen_out <= 1'b0;
            chain_settled_out      <= 1'b0;
        end else begin
            // every device's enable computed at once, no serial ripple
            chain_enable_in_out    <= la_next;
            return_prefix_seen_out <= prefix_reg;
            chain_settled_out      <= (state_reg == `IAWDC_ST_VECTOR);
        end
    end
endmodule

`default_nettype wire

/* rtl/iawdc_sync3.v */
// three-flop input synchroniser with agreement filter
// assumes input from outside the clk_sys_in domain
`timescale 1ns/10ps
`default_nettype none

module iawdc_sync3 (
    input  wire clk_sys_in,
    input  wire rst_n_in,
    input  wire async_in,
    input  wire rst_val_in,
    output reg  level_out
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // only s2 and s3 are compared; s1 feeds s2 only
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s1_reg    <= rst_val_in;
            s2_reg    <= rst_val_in;
            s3_reg    <= rst_val_in;
            level_out <= rst_val_in;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_out <= s3_reg;
            end
        end
    end
endmodule

`default_nettype wire

/* tb/iawdc_chain_model.sv */
// daisy chain peripherals, own enable output per device
// assumes look-ahead wiring in the glue block
`timescale 1ns/10ps
`default_nettype none
module iawdc_chain_model (
    input  wire logic [7:0] pending_in,
    input  wire logic [7:0] in_service_in,
    input  wire logic       prefix_in,
    output logic      [7:0] enable_out
);
    // in service holds low, prefix byte lifts a pending device
    assign enable_out = ~in_service_in & (~pending_in | {8{prefix_in}});
endmodule
`default_nettype wire

/* tb/iawdc_checker.sv */
// port checks for the acknowledge glue block
// assumes it is bound onto iawdc_glue
`timescale 1ns/10ps
`default_nettype none
module iawdc_checker (
    input wire logic       clk_sys_in,
    input wire logic       rst_n_in,
    input wire logic       snoop_enable_in,
    input wire logic [3:0] add_wait_in,
    input wire logic [7:0] chain_enable_out_in,
    input wire logic       wait_n_out,
    input wire logic       delayed_io_request_n_out,
    input wire logic       vector_acknowledge_n_out,
    input wire logic       periph_rd_n_out,
    input wire logic [7:0] chain_enable_in_out
);
    logic [4:0] cnt_reg;
    logic [7:0] la;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // ====
    // wait span counter and look-ahead model
    always @(posedge clk_sys_in) cnt_reg <= (!rst_n_in || wait_n_out) ? 5'h00 : cnt_reg + 5'h01;
    always_comb begin
        la[0] = 1'b1;
        for (int i = 1; i < 8; i++) la[i] = la[i-1] & chain_enable_out_in[i-1];
    end
    wait_len_a: assert property ($rose(wait_n_out) |-> cnt_reg == {1'b0, add_wait_in})
        else $error("wait span");
    req_late_a: assert property ($fell(delayed_io_request_n_out) |-> wait_n_out
        && (add_wait_in == 4'h0 || !$past(wait_n_out))) else $error("early request");
    rd_late_a: assert property ($fell(periph_rd_n_out) && !vector_acknowledge_n_out |-> wait_n_out
        && (add_wait_in == 4'h0 || !$past(wait_n_out))) else $error("early read");
    req_held_a: assert property (!wait_n_out |-> delayed_io_request_n_out && periph_rd_n_out)
        else $error("strobe in wait");
    snoop_off_a: assert property (!snoop_enable_in |-> delayed_io_request_n_out) else $error("snoop off");
    ack_first_a: assert property ($fell(wait_n_out) |-> !vector_acknowledge_n_out) else $error("no ack");
    rd_ack_a: assert property ($rose(wait_n_out) |-> !periph_rd_n_out && !vector_acknowledge_n_out)
        else $error("read alone");
    look_ahead_a: assert property ($past(rst_n_in) |-> chain_enable_in_out == $past(la))
        else $error("chain enable");
endmodule
bind iawdc_glue iawdc_checker u_chk (.*);
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the acknowledge glue block
// assumes the chain model and the bound checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; $display("Error %0t mismatch", $time); end end
module testbench;
    logic       clk = 1'b0, rst_n = 1'b0, fetch_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, io_n = 1'b1, snoop = 1'b1;
    logic [7:0] data = 8'h00, pend = 8'h00, isv = 8'h00;
    logic [3:0] add_w = 4'h0;
    // rows: added waits, snoop, pending, in service, expected enables
    logic [28:0] rows [4] = '{{4'h0, 1'b1, 24'h0000ff}, {4'h1, 1'b0, 24'h040007}, {4'h2, 1'b1, 24'h000101},
                              {4'hf, 1'b1, 24'h8000ff}};
    wire logic [7:0] ceo, cei;
    wire logic       wait_n, dreq_n, vack_n, prd_n, pwr_n, pfx, settled;
    int err_total = 0, n_compared = 0;
    iawdc_glue DUT (.clk_sys_in(clk), .rst_n_in(rst_n), .opcode_fetch_cycle_n_in(fetch_n), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .io_request_strobe_n_in(io_n), .data_bus_in(data), .add_wait_in(add_w),
        .snoop_enable_in(snoop), .chain_enable_out_in(ceo), .wait_n_out(wait_n), .delayed_io_request_n_out(dreq_n),
        .vector_acknowledge_n_out(vack_n), .periph_rd_n_out(prd_n), .periph_wr_n_out(pwr_n),
        .chain_enable_in_out(cei), .return_prefix_seen_out(pfx), .chain_settled_out(settled));
    iawdc_chain_model u_chain (.pending_in(pend), .in_service_in(isv), .prefix_in(pfx), .enable_out(ceo));
    initial forever #4 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic summarize;
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ack(input logic [28:0] r);
        int k;
        {add_w, snoop, pend, isv} = r[28:8];
        fetch_n = 1'b0;
        for (k = 0; vack_n !== 1'b0 && k < 20; k++) step(1);
        `CHK(vack_n, 1'b0)
        io_n = 1'b0;
        for (k = 0; wait_n !== 1'b0 && prd_n !== 1'b0 && k < 20; k++) step(1);
        for (k = 0; wait_n === 1'b0 && k < 40; k++) step(1);
        `CHK(k, int'(r[28:25]))
        `CHK({dreq_n, prd_n}, {~r[24], 1'b0})
        step(1);
        `CHK(settled, 1'b1)
        io_n = 1'b1;
        step(6);
        `CHK({dreq_n, prd_n, settled}, 3'h6)
        fetch_n = 1'b1;
        step(6);
        `CHK({vack_n, cei}, {1'b1, r[7:0]})
    endtask
    initial begin
        step(4);
        rst_n = 1'b1;
        step(2);
        `CHK({wait_n, dreq_n, vack_n, prd_n, pwr_n, pfx, settled, cei}, 15'h7cff)
        foreach (rows[i]) ack(rows[i]);
        pend = 8'h04;
        data = 8'hed;
        {fetch_n, rd_n} = 2'b00;
        step(8);
        `CHK({pfx, vack_n, cei}, 10'h3ff)
        {fetch_n, rd_n} = 2'b11;
        step(6);
        data = 8'h4d;
        {fetch_n, rd_n} = 2'b00;
        step(8);
        `CHK({pfx, cei}, 9'h007)
        {fetch_n, rd_n, wr_n} = 3'b110;
        step(6);
        `CHK(pwr_n, 1'b0)
        wr_n = 1'b1;
        add_w = 4'hf;
        {fetch_n, io_n} = 2'b00;
        step(12);
        {rst_n, fetch_n, io_n} = 3'b011;
        step(1);
        `CHK({wait_n, vack_n}, 2'h3)
        step(4);
        rst_n = 1'b1;
        step(4);
        `CHK({wait_n, dreq_n, vack_n, prd_n, pwr_n, pfx, settled, cei}, 15'h7c07)
        summarize();
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
